// ===== src/igc_pkg.sv
// package: register map, field positions and encodings of the global control bank
package igc_pkg;

  // register offsets (byte addresses, one aligned word each)
  localparam logic [11:0] OFS_SEC_CTRL    = 12'h000;
  localparam logic [11:0] OFS_NS_CTRL     = 12'h004;
  localparam logic [11:0] OFS_AUX_CTRL    = 12'h008;
  localparam logic [11:0] OFS_SEC_AUX     = 12'h00C;
  localparam logic [11:0] OFS_FAULT_STAT  = 12'h010;
  localparam logic [11:0] OFS_CFG         = 12'h014;

  // control register field positions
  localparam int BSU_HI   = 15;
  localparam int BSU_LO   = 14;
  localparam int FB_BIT   = 13;
  localparam int PTM_BIT  = 12;
  localparam int VMP_BIT  = 11;
  localparam int USF_BIT  = 10;
  localparam int GSE_BIT  = 9;
  localparam int STD_BIT  = 8;
  localparam int GCFI_BIT = 5;
  localparam int GCFA_BIT = 4;
  localparam int GFI_BIT  = 2;
  localparam int GFA_BIT  = 1;
  localparam int CPD_BIT  = 0;

  // auxiliary register field positions
  localparam int CTXB_BIT = 10;
  localparam int XOFF_BIT = 9;
  localparam int NOMB_BIT = 8;
  localparam int WC2_BIT  = 2;
  localparam int WC1_BIT  = 1;
  localparam int PF_BIT   = 0;

  // writable masks, reset values and the fixed read-one bit; reserved and fixed bits excluded from the masks
  localparam logic [31:0] CTRL_WMASK   = 32'h0000_FC37;
  localparam logic [31:0] SCTRL_WMASK  = 32'h0000_F437;
  localparam logic [31:0] AUX_WMASK    = 32'h0000_0707;
  localparam logic [31:0] SAUX_WMASK   = 32'h0000_0700;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
  localparam logic [31:0] AUX_RESET    = 32'h0000_0000;
  localparam logic [31:0] STALL_DISABLE_RO    = 32'h0000_0100;

  // shareability domains, ordered by reach
  typedef enum logic [1:0] {
    IGC_SH_NONE  = 2'b00,
    IGC_SH_INNER = 2'b01,
    IGC_SH_OUTER = 2'b10,
    IGC_SH_SYS   = 2'b11
  } igc_share_e;

  // maintenance operation kinds
  typedef enum logic [2:0] {
    IGC_OP_OTHER  = 3'h0,
    IGC_OP_TLBI   = 3'h1,
    IGC_OP_BRANCH_PRED_INVAL_ALL = 3'h2,
    IGC_OP_ICALL  = 3'h3
  } igc_op_e;

  // client transaction request
  typedef struct packed {
    logic       valid;
    logic       secure;
    logic       matched;
    logic       ctx_assigned;
    logic       ctx_xlate_on;
    logic       is_barrier;
    logic       barrier_mapped;
    igc_share_e barrier_share;
    logic       is_maint;
    igc_op_e    maint_op;
    logic       maint_bcast;
    logic       maint_has_vmid;
  } igc_txn_s;

  // steering decision back to the datapath
  typedef struct packed {
    logic       bypass;
    logic       bypass_tlb_fill;
    logic       usf_fault;
    igc_share_e barrier_share;
    logic       maint_bcast;
    logic       maint_may_skip;
    logic       stall_enable;
  } igc_steer_s;

  // bus-shareability upgrade: never lowers a domain
  function automatic igc_share_e igc_max_share(igc_share_e a, igc_share_e b);
    return (a > b) ? a : b;
  endfunction

endpackage

// ===== src/igc_regs.sv
// global control register bank and transaction steering of the translation unit
// Operation
// - unmapped barriers raised to at least the upgrade field domain
// - upgrade only in lite coherency config, only on barriers received here
// - force broadcast turns maintenance ops into inner shareable broadcasts
// - private namespace lets VMID-tagged broadcast invalidates skip cached entries
// - secure control register treats the private namespace bit as reserved
// - unmatched stream fault bit resets 0; 0 passes, 1 faults
// - global stall enable reads zero, writes ignored
// - stall disable reads one, writes ignored
// - non-secure stall disable governs non-secure context banks
// - config fault interrupt only when its enable is set
// - config fault abort only when its report enable is set
// - global fault interrupt only when its enable is set
// - global fault abort only when its report enable is set
// - client port disable resets 1; 1 bypasses translation entirely
// - walk caches and prefetch enable exist only in non-secure auxiliary
// - aux bits 0-2 non-secure only; bits 8-10 in both copies
// - stream-to-context bypass details cached when its enable set
// - translation-off context attributes cached when its enable set
// - no-match bypass details cached when its enable set
// - second walk cache enabled by its bit
// - first walk cache enabled by its bit
// - prefetch of next entry on third-level walk when enabled
// - force broadcast leaves other operations unchanged
// - bypass when port disabled or unmatched with fault bit clear
`timescale 1ns/100ps

module igc_regs
  import igc_pkg::*;
#(
  parameter bit LITE_COHERENT = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire igc_txn_s    txn,
  output igc_steer_s       steer,
  input  wire logic        gcfg_fault,
  input  wire logic        gcfg_fault_secure,
  input  wire logic        gfault,
  input  wire logic        gfault_secure,
  output logic             gcfg_fault_irq,
  output logic             gcfg_fault_abort,
  output logic             gfault_irq,
  output logic             gfault_abort,
  output logic             walk_cache_two_en,
  output logic             walk_cache_one_en,
  output logic             walk_prefetch_en
);

  logic [31:0] sec_ctrl;
  logic [31:0] ns_ctrl;
  logic [31:0] aux_ctrl;
  logic [31:0] sec_aux;
  logic [3:0]  fault_seen;
  logic [31:0] next_rdata;
  logic [31:0] sel_ctrl;
  logic [31:0] sel_aux;
  igc_share_e  upg;
  logic        bypass_cpd;
  logic        bypass_nom;

  // secure control: namespace bit never stored, stall bits fixed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sec_ctrl <= CTRL_RESET;
    end else if (reg_wr && reg_addr == OFS_SEC_CTRL) begin
      sec_ctrl <= reg_wdata & SCTRL_WMASK;
    end
  end

  // non-secure control
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ns_ctrl <= CTRL_RESET;
    end else if (reg_wr && reg_addr == OFS_NS_CTRL) begin
      ns_ctrl <= reg_wdata & CTRL_WMASK;
    end
  end

  // non-secure auxiliary copy holds all six enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_ctrl <= AUX_RESET;
    end else if (reg_wr && reg_addr == OFS_AUX_CTRL) begin
      aux_ctrl <= reg_wdata & AUX_WMASK;
    end
  end

  // secure auxiliary copy: only the banked bypass-cache enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sec_aux <= AUX_RESET;
    end else if (reg_wr && reg_addr == OFS_SEC_AUX) begin
      sec_aux <= reg_wdata & SAUX_WMASK;
    end
  end

  // sticky fault record; a new fault wins over the write-one clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_seen <= 4'h0;
    end else begin
      fault_seen <= (fault_seen & ~((reg_wr && reg_addr == OFS_FAULT_STAT) ?
                     reg_wdata[3:0] : 4'h0)) |
                    {gfault_secure & gfault, gfault,
                     gcfg_fault_secure & gcfg_fault, gcfg_fault};
    end
  end

  // read mux; fixed stall bits folded in, unmapped reads zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (reg_addr)
      OFS_SEC_CTRL:   next_rdata = sec_ctrl | STALL_DISABLE_RO;
      OFS_NS_CTRL:    next_rdata = ns_ctrl | STALL_DISABLE_RO;
      OFS_AUX_CTRL:   next_rdata = aux_ctrl;
      OFS_SEC_AUX:    next_rdata = sec_aux;
      OFS_FAULT_STAT: next_rdata = {28'h000_0000, fault_seen};
      OFS_CFG:        next_rdata = {31'h0000_0000, LITE_COHERENT};
      default:        next_rdata = 32'h0000_0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
    end
  end

  // bank selection by transaction security
  assign sel_ctrl = txn.secure ? sec_ctrl : ns_ctrl;
  assign sel_aux  = txn.secure ? sec_aux : aux_ctrl;
  assign upg      = igc_share_e'(sel_ctrl[BSU_HI:BSU_LO]);

  // bypass decision
  assign bypass_cpd = sel_ctrl[CPD_BIT];
  assign bypass_nom = !txn.matched && !sel_ctrl[USF_BIT];

  // steering towards the datapath, registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      steer <= '0;
    end else begin
      steer.bypass <= txn.valid && (bypass_cpd || bypass_nom);
      steer.usf_fault <= txn.valid && !bypass_cpd && !txn.matched
                         && sel_ctrl[USF_BIT];
      steer.bypass_tlb_fill <= txn.valid && (
          (bypass_nom && !bypass_cpd && sel_aux[NOMB_BIT]) ||
          (txn.matched && !txn.ctx_assigned && sel_aux[CTXB_BIT]) ||
          (txn.ctx_assigned && !txn.ctx_xlate_on && sel_aux[XOFF_BIT]));
      // only received barriers of unmapped clients, lite config only
      if (txn.valid && txn.is_barrier && !txn.barrier_mapped && LITE_COHERENT) begin
        steer.barrier_share <= igc_max_share(txn.barrier_share, upg);
      end else begin
        steer.barrier_share <= txn.barrier_share;
      end
      // forced broadcast only on the three maintenance kinds
      steer.maint_bcast <= txn.maint_bcast || (txn.valid && txn.is_maint &&
          sel_ctrl[FB_BIT] && txn.maint_op != IGC_OP_OTHER);
      // hint only; secure side has no namespace bit
      steer.maint_may_skip <= txn.valid && txn.maint_bcast && txn.maint_has_vmid
                              && !txn.secure && ns_ctrl[VMP_BIT];
      // non-secure stall disable rules non-secure banks; always disabled
      steer.stall_enable <= 1'b0;
    end
  end

  // fault responses gated by the bank of the faulting access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gcfg_fault_irq   <= 1'b0;
      gcfg_fault_abort <= 1'b0;
      gfault_irq       <= 1'b0;
      gfault_abort     <= 1'b0;
    end else begin
      gcfg_fault_irq   <= gcfg_fault &&
        (gcfg_fault_secure ? sec_ctrl[GCFI_BIT] : ns_ctrl[GCFI_BIT]);
      gcfg_fault_abort <= gcfg_fault &&
        (gcfg_fault_secure ? sec_ctrl[GCFA_BIT] : ns_ctrl[GCFA_BIT]);
      gfault_irq       <= gfault &&
        (gfault_secure ? sec_ctrl[GFI_BIT] : ns_ctrl[GFI_BIT]);
      gfault_abort     <= gfault &&
        (gfault_secure ? sec_ctrl[GFA_BIT] : ns_ctrl[GFA_BIT]);
    end
  end

  // walk engine enables come from the non-secure copy only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      walk_cache_two_en <= 1'b0;
      walk_cache_one_en <= 1'b0;
      walk_prefetch_en  <= 1'b0;
    end else begin
      walk_cache_two_en <= aux_ctrl[WC2_BIT];
      walk_cache_one_en <= aux_ctrl[WC1_BIT];
      walk_prefetch_en  <= aux_ctrl[PF_BIT];
    end
  end

endmodule

// ===== testbench/igc_client_model.sv
// client master model: presents transaction descriptors to the bank
`timescale 1ns/100ps

module igc_client_model
  import igc_pkg::*;
(
  input  wire igc_txn_s req,
  output igc_txn_s      txn
);
  // idle: all fields inverted, valid included, since the zero pad is cut off in the cast; valid thus reads high
  assign txn = req.valid ? req : igc_txn_s'({1'b0, ~req[14:0]});
endmodule

// ===== testbench/igc_regs_checker.sv
// checker: port-level relations of the global control bank
`timescale 1ns/100ps

module igc_regs_checker
  import igc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire igc_txn_s    txn,
  input wire igc_steer_s  steer,
  input wire logic        gcfg_fault,
  input wire logic        gfault,
  input wire logic        gcfg_fault_irq,
  input wire logic        gcfg_fault_abort,
  input wire logic        gfault_irq,
  input wire logic        gfault_abort
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  chk_upper_zero: assert property (reg_rd |=> reg_rdata[31:16] == 16'h0000)
    else $error("reserved upper bits read nonzero");
  chk_stall_fixed: assert property (reg_rd && reg_addr == OFS_NS_CTRL
    |=> reg_rdata[STD_BIT] && !reg_rdata[GSE_BIT]) else $error("stall bits not fixed");
  chk_no_stall: assert property (!steer.stall_enable)
    else $error("stalling enabled");
  chk_gf_irq: assert property (gfault_irq |-> $past(gfault))
    else $error("fault interrupt without fault");
  chk_gf_abort: assert property (gfault_abort |-> $past(gfault))
    else $error("fault abort without fault");
  chk_cfg_irq: assert property (gcfg_fault_irq |-> $past(gcfg_fault))
    else $error("config interrupt without fault");
  chk_cfg_abort: assert property (gcfg_fault_abort |-> $past(gcfg_fault))
    else $error("config abort without fault");
  chk_barrier_floor: assert property (txn.valid && txn.is_barrier
    |=> steer.barrier_share >= $past(txn.barrier_share)) else $error("barrier lowered");
  chk_other_op: assert property (txn.valid && txn.is_maint && txn.maint_op == IGC_OP_OTHER
    |=> steer.maint_bcast == $past(txn.maint_bcast)) else $error("other op altered");
  chk_usf_cause: assert property (steer.usf_fault |-> !$past(txn.matched))
    else $error("stream fault on matched txn");

  // main scenarios reached
  cover property (steer.usf_fault);
  cover property (gfault_irq && gfault_abort);
  cover property (steer.bypass_tlb_fill);
endmodule

// ===== testbench/test_iommu_global_control_regs.sv
// testbench: register bank and steering scenarios
`timescale 1ns/100ps

module test_iommu_global_control_regs;
  import igc_pkg::*;
  logic        clk, rst_b, reg_wr, reg_rd, gf, gcf, gf_irq, gf_ab, gcf_irq, gcf_ab, wc2, wc1, pf;
  logic        gfs, gcfs;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  igc_txn_s    cmd, txn;
  igc_steer_s  steer;
  int          error_cnt = 0;
  int          n_checks = 0;

  igc_client_model i_igc_client_model (.req(cmd), .txn(txn));
  // secure fault flags pick which bank gates each fault
  igc_regs i_igc_regs (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txn(txn), .steer(steer),
    .gcfg_fault(gcf), .gcfg_fault_secure(gcfs), .gfault(gf), .gfault_secure(gfs),
    .gcfg_fault_irq(gcf_irq), .gcfg_fault_abort(gcf_ab), .gfault_irq(gf_irq),
    .gfault_abort(gf_ab), .walk_cache_two_en(wc2), .walk_cache_one_en(wc1),
    .walk_prefetch_en(pf));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  // steering is judged one edge after the descriptor is driven
  task automatic send(input igc_txn_s t);
    @(posedge clk);
    cmd <= t;
    @(posedge clk);
    #1;
  endtask

  task automatic t_steer;
    igc_txn_s t;
    rd(OFS_NS_CTRL, 32'h0000_0101);
    rd(OFS_AUX_CTRL, 32'h0000_0000);
    t = '0;
    t.valid = 1'b1;
    t.matched = 1'b1;
    t.ctx_assigned = 1'b1;
    t.ctx_xlate_on = 1'b1;
    send(t);
    chk(steer.bypass, 1'b1);
    wr(OFS_NS_CTRL, 32'h0000_0000);
    send(t);
    chk(steer.bypass, 1'b0);
    t.matched = 1'b0;
    send(t);
    chk({steer.bypass, steer.usf_fault}, 2'b10);
    wr(OFS_NS_CTRL, 32'h0000_0400);
    send(t);
    chk({steer.bypass, steer.usf_fault}, 2'b01);
  endtask

  task automatic t_masks;
    logic [11:0] a [5] = '{OFS_NS_CTRL, OFS_SEC_CTRL, OFS_AUX_CTRL, OFS_SEC_AUX, 12'h020};
    logic [31:0] e [5] = '{32'h0000_FD37, 32'h0000_F537, 32'h0000_0707, 32'h0000_0700, 32'h0};
    for (int i = 0; i < 5; i++) begin
      wr(a[i], 32'hFFFF_FFFF);
      rd(a[i], e[i]);
    end
    // configuration word is read only
    wr(OFS_CFG, 32'h0000_0000);
    rd(OFS_CFG, 32'h0000_0001);
    chk({wc2, wc1, pf}, 3'b111);
    wr(OFS_AUX_CTRL, 32'h0000_0000);
    @(posedge clk);
    #1 chk({wc2, wc1, pf}, 3'b000);
  endtask

  // each bypass kind fills only under its own enable
  task automatic t_fill;
    igc_txn_s t;
    logic [31:0] m;
    wr(OFS_NS_CTRL, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      t = '0;
      t.valid = 1'b1;
      t.matched = (i != 0);
      t.ctx_assigned = (i == 2);
      m = (i == 0) ? 32'h0000_0100 : (i == 1) ? 32'h0000_0400 : 32'h0000_0200;
      for (int k = 0; k < 2; k++) begin
        wr(OFS_AUX_CTRL, k ? m : (32'h0000_0700 ^ m));
        send(t);
        chk(steer.bypass_tlb_fill, k);
      end
    end
  endtask

  // each bank gates its own faults; the other bank is kept disabled
  task automatic t_fault;
    for (int s = 0; s < 2; s++) begin
      for (int en = 1; en >= 0; en--) begin
        wr(OFS_NS_CTRL, (en && !s) ? 32'h0000_0036 : 32'h0000_0000);
        wr(OFS_SEC_CTRL, (en && s) ? 32'h0000_0036 : 32'h0000_0000);
        @(posedge clk);
        gf <= 1'b1;
        gcf <= 1'b1;
        gfs <= s[0];
        gcfs <= s[0];
        @(posedge clk);
        gf <= 1'b0;
        gcf <= 1'b0;
        #1 chk({gcf_irq, gcf_ab, gf_irq, gf_ab}, en ? 4'hF : 4'h0);
      end
    end
    rd(OFS_FAULT_STAT, 32'h0000_000F);
    // clear and a new fault in one cycle: the new fault stays recorded
    @(posedge clk);
    reg_addr <= OFS_FAULT_STAT;
    reg_wdata <= 32'h0000_000F;
    reg_wr <= 1'b1;
    gf <= 1'b1;
    gfs <= 1'b0;
    gcfs <= 1'b0;
    @(posedge clk);
    reg_wr <= 1'b0;
    gf <= 1'b0;
    rd(OFS_FAULT_STAT, 32'h0000_0004);
  endtask

  task automatic t_maint;
    igc_txn_s t;
    wr(OFS_NS_CTRL, 32'h0000_2000);
    t = '0;
    t.valid = 1'b1;
    t.matched = 1'b1;
    t.is_maint = 1'b1;
    for (int op = 0; op < 4; op++) begin
      t.maint_op = igc_op_e'(op);
      send(t);
      chk(steer.maint_bcast, op != 0);
    end
    wr(OFS_NS_CTRL, 32'h0000_0800);
    t.maint_op = IGC_OP_TLBI;
    t.maint_bcast = 1'b1;
    t.maint_has_vmid = 1'b1;
    send(t);
    chk(steer.maint_may_skip, 1'b1);
    wr(OFS_SEC_CTRL, 32'h0000_0800);
    t.secure = 1'b1;
    send(t);
    chk(steer.maint_may_skip, 1'b0);
  endtask

  task automatic t_barrier;
    igc_txn_s t;
    t = '0;
    t.valid = 1'b1;
    t.is_barrier = 1'b1;
    t.barrier_share = IGC_SH_INNER;
    for (int b = 0; b < 4; b++) begin
      wr(OFS_NS_CTRL, 32'(b) << 14);
      send(t);
      chk(steer.barrier_share, (b > 1) ? b : 1);
    end
    t.barrier_mapped = 1'b1;
    send(t);
    chk(steer.barrier_share, IGC_SH_INNER);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #100us;
    error_cnt++;
    report_and_stop;
  end

  initial begin
    {rst_b, reg_wr, reg_rd, gf, gcf, gfs, gcfs} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    cmd = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_steer;
    t_masks;
    t_fill;
    t_fault;
    t_maint;
    t_barrier;
    report_and_stop;
  end
endmodule

bind igc_regs igc_regs_checker i_igc_regs_checker (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txn(txn), .steer(steer),
  .gcfg_fault(gcfg_fault), .gfault(gfault), .gcfg_fault_irq(gcfg_fault_irq),
  .gcfg_fault_abort(gcfg_fault_abort), .gfault_irq(gfault_irq), .gfault_abort(gfault_abort));
